// file: lvdc_core.sv
`timescale 1ns/1ps
// Contract
// - Enable bit starts comparison when one, stops all detection when zero.
// - Source bit picks supply comparison at zero, external pin at one.
// - Action bit picks interrupt at zero, internal reset at one.
// - Flag reads one only while enabled and monitored voltage is below.
// - Flag bit is read-only; the other implemented control bits are writable.
// - Enable, source and action bits survive only a detector reset.
// - Enabled in interrupt mode, the flag value is the interrupt request.
// - Any reset loads the control register with zero, minus retention.
// - Level register holds a four-bit threshold code, reset to zero.
// - With the pin monitored the threshold is fixed; level code ignored.
// - Five port direction bits, one means input; reset loads all ones.
// - Reset mode holds internal reset while below, releases when above.
// - Setting the action bit while above threshold causes no reset.
// - In interrupt mode a below level may interrupt right after enabling.
// - Detector reset sets the source flag; any reset sets the mask.
module lvdc_core
   import lvdc_pkg::*;
(
   // Clock and power-on or pin reset.
   input  wire logic        ref_clk,
   input  wire logic        rst,

   // Special-function register port.
   input  wire logic [15:0] sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic        sfr_bit_op,
   input  wire logic [2:0]  sfr_bit_sel,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,

   // Reset controller side.
   input  wire logic        other_reset,
   input  wire logic        reset_source_clear,
   output logic             detector_reset,
   output logic             detector_reset_source_flag,
   output logic             detector_irq_mask_set,

   // Interrupt controller side.
   output logic             detector_irq,

   // Analog comparator side.
   input  wire logic        comparator_below,
   output logic             comparator_enable,
   output logic             compare_external,
   output logic [3:0]       comparator_level_code,

   // Port buffer control.
   output logic [4:0]       port_pin_direction
);

   // All state of the detector control.
   typedef struct packed {
      logic                    detector_enable;
      logic                    source_select;
      logic                    action_mode;
      logic [LVDC_LEVEL_W-1:0] level_code;
      logic [LVDC_PORT_W-1:0]  port_dir;
      logic                    flag;
      logic                    irq;
      logic                    src_flag;
      logic                    mask_set;
      lvdc_state_type          state;
   } lvdc_core_state_type;

   // Reset image; the control, level and direction registers follow the package.
   localparam lvdc_core_state_type LVDC_CORE_RESET = '{
      detector_enable: LVDC_CONTROL_RESET[LVDC_CTRL_ENABLE_BIT],
      source_select:   LVDC_CONTROL_RESET[LVDC_CTRL_SOURCE_BIT],
      action_mode:     LVDC_CONTROL_RESET[LVDC_CTRL_MODE_BIT],
      level_code:      LVDC_LEVEL_RESET[LVDC_LEVEL_W-1:0],
      port_dir:        LVDC_PORT_DIR_RESET[LVDC_PORT_W-1:0],
      flag:            1'b0,
      irq:             1'b0,
      src_flag:        1'b0,
      mask_set:        1'b1,
      state:           LVDC_OFF
   };

   lvdc_core_state_type q;
   lvdc_core_state_type next_q;
   logic                below_sync;
   logic [7:0]          control_image;
   logic                below_now;

   lvdc_sfr_if regs ();

   // Comparator output is brought onto the clock by two flip-flops.
   lvdc_sync u_below_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (comparator_below),
      .sync_out (below_sync)
   );

   // Address decode, bit-write merging and registered read data.
   lvdc_sfr_access u_access (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .sfr_addr    (sfr_addr),
      .sfr_wr      (sfr_wr),
      .sfr_rd      (sfr_rd),
      .sfr_bit_op  (sfr_bit_op),
      .sfr_bit_sel (sfr_bit_sel),
      .sfr_wdata   (sfr_wdata),
      .sfr_rdata   (sfr_rdata),
      .regs        (regs)
   );

   // Control image with reserved bits at zero and the live flag at bit 0.
   always_comb begin
      control_image                       = 8'h00;
      control_image[LVDC_CTRL_ENABLE_BIT] = q.detector_enable;
      control_image[LVDC_CTRL_SOURCE_BIT] = q.source_select;
      control_image[LVDC_CTRL_MODE_BIT]   = q.action_mode;
      control_image[LVDC_CTRL_FLAG_BIT]   = q.flag;
   end

   // Images offered to the decoder for reads and single-bit merges.
   assign regs.control_q  = control_image;
   assign regs.level_q    = {{(8-LVDC_LEVEL_W){1'b0}}, q.level_code};
   assign regs.port_dir_q = LVDC_PORT_DIR_FIXED |
                            {{(8-LVDC_PORT_W){1'b0}}, q.port_dir};

   // Whichever source is routed, the analog side reports one below level.
   // The synchronised value only counts while the detector is running.
   assign below_now = q.detector_enable & below_sync;

   // Next-state logic for registers, flag, request lines and sequencing.
   always_comb begin
      next_q = q;

      // Software writes; the flag and reserved bits are not stored.
      if (regs.wr_control) begin
         next_q.detector_enable =
            regs.wr_value[LVDC_CTRL_ENABLE_BIT];
         next_q.source_select =
            regs.wr_value[LVDC_CTRL_SOURCE_BIT];
         next_q.action_mode =
            regs.wr_value[LVDC_CTRL_MODE_BIT];
      end
      if (regs.wr_level) begin
         next_q.level_code = regs.wr_value[LVDC_LEVEL_W-1:0];
      end
      if (regs.wr_port_dir) begin
         next_q.port_dir = regs.wr_value[LVDC_PORT_W-1:0];
      end

      // Live flag; it falls to zero on the edge after the detector is disabled.
      next_q.flag = below_now;

      // Sequencing: a reset is raised only by a below level seen in
      // reset mode, so arming while above threshold does nothing.
      case (q.state)
         LVDC_OFF: begin
            if (q.detector_enable) begin
               next_q.state = LVDC_WATCH;
            end
         end
         LVDC_WATCH: begin
            if (!q.detector_enable) begin
               next_q.state = LVDC_OFF;
            end else if (q.action_mode && below_now) begin
               next_q.state = LVDC_RESETTING;
            end
         end
         LVDC_RESETTING: begin
            if (!below_now || !q.action_mode) begin
               next_q.state = q.detector_enable ? LVDC_WATCH
                                                : LVDC_OFF;
            end
         end
         default: begin
            next_q.state = LVDC_OFF;
         end
      endcase

      // Interrupt request mirrors the flag in interrupt mode, at once
      // after enabling if the level is already below.
      next_q.irq = below_now & ~q.action_mode;

      // While this detector holds the chip in reset, the control bits
      // keep their values and the other registers take reset values.
      if (q.state == LVDC_RESETTING) begin
         next_q.detector_enable = q.detector_enable;
         next_q.source_select   = q.source_select;
         next_q.action_mode     = q.action_mode;
         next_q.level_code      = LVDC_LEVEL_RESET[LVDC_LEVEL_W-1:0];
         next_q.port_dir        = LVDC_PORT_DIR_RESET[LVDC_PORT_W-1:0];
         next_q.irq             = 1'b0;
      end

      // Any other reset clears the control bits too.
      if (other_reset) begin
         next_q.detector_enable = LVDC_CONTROL_RESET[LVDC_CTRL_ENABLE_BIT];
         next_q.source_select   = LVDC_CONTROL_RESET[LVDC_CTRL_SOURCE_BIT];
         next_q.action_mode     = LVDC_CONTROL_RESET[LVDC_CTRL_MODE_BIT];
         next_q.level_code      = LVDC_LEVEL_RESET[LVDC_LEVEL_W-1:0];
         next_q.port_dir        = LVDC_PORT_DIR_RESET[LVDC_PORT_W-1:0];
         next_q.flag            = 1'b0;
         next_q.irq             = 1'b0;
         next_q.state           = LVDC_OFF;
      end

      // Reset-source flag: held across other resets, cleared by the
      // reset controller, and a detector reset wins over that clear.
      if (reset_source_clear) begin
         next_q.src_flag = 1'b0;
      end
      if (q.state == LVDC_RESETTING) begin
         next_q.src_flag = 1'b1;
      end

      // Interrupt mask is set by every kind of reset.
      next_q.mask_set = other_reset | (q.state == LVDC_RESETTING);
   end

   // One register stage for all state; power-on reset loads the image.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= LVDC_CORE_RESET;
      end else begin
         q <= next_q;
      end
   end

   // Reset request is asserted exactly while the sequencer holds it.
   assign detector_reset             = (q.state == LVDC_RESETTING);
   assign detector_reset_source_flag = q.src_flag;
   assign detector_irq_mask_set      = q.mask_set;
   assign detector_irq               = q.irq;

   // Analog controls; the pin source uses the fixed reference.
   assign comparator_enable     = q.detector_enable;
   assign compare_external      = q.source_select;
   assign comparator_level_code = q.source_select ? LVDC_LEVEL_UNUSED
                                                  : q.level_code;

   // Direction bits: one is input with buffer off.
   assign port_pin_direction = q.port_dir;

endmodule // lvdc_core

// file: lvdc_pkg.sv
package lvdc_pkg;

   // Register byte addresses on the special-function register port.
   localparam logic [15:0] LVDC_ADDR_PORT_DIR = 16'hff2c;
   localparam logic [15:0] LVDC_ADDR_CONTROL  = 16'hffbe;
   localparam logic [15:0] LVDC_ADDR_LEVEL    = 16'hffbf;

   // Field positions inside the low_voltage_control register.
   localparam int LVDC_CTRL_ENABLE_BIT = 7;
   localparam int LVDC_CTRL_SOURCE_BIT = 2;
   localparam int LVDC_CTRL_MODE_BIT   = 1;
   localparam int LVDC_CTRL_FLAG_BIT   = 0;

   // Field widths of the level code and the port direction bits.
   localparam int LVDC_LEVEL_W = 4;
   localparam int LVDC_PORT_W  = 5;

   // Reset values of the three registers.
   localparam logic [7:0] LVDC_CONTROL_RESET  = 8'h00;
   localparam logic [7:0] LVDC_LEVEL_RESET    = 8'h00;
   localparam logic [7:0] LVDC_PORT_DIR_RESET = 8'hff;

   // Unimplemented upper direction bits always read as one.
   localparam logic [7:0] LVDC_PORT_DIR_FIXED = 8'he0;

   // Level code driven to the analog side when the pin is monitored.
   localparam logic [3:0] LVDC_LEVEL_UNUSED = 4'h0;

   // Detector sequencing states.
   typedef enum logic [1:0] {
      LVDC_OFF,
      LVDC_WATCH,
      LVDC_RESETTING
   } lvdc_state_type;

endpackage

// file: lvdc_sfr_if.sv
`timescale 1ns/1ps
interface lvdc_sfr_if;
   import lvdc_pkg::*;

   // Current register images, as software would read them.
   logic [7:0] control_q;
   logic [7:0] level_q;
   logic [7:0] port_dir_q;

   // Decoded write strobes and the byte to store.
   logic       wr_control;
   logic       wr_level;
   logic       wr_port_dir;
   logic [7:0] wr_value;

   modport decoder (
      input  control_q,
      input  level_q,
      input  port_dir_q,
      output wr_control,
      output wr_level,
      output wr_port_dir,
      output wr_value
   );

   modport core (
      output control_q,
      output level_q,
      output port_dir_q,
      input  wr_control,
      input  wr_level,
      input  wr_port_dir,
      input  wr_value
   );
endinterface

// file: lvdc_sync.sv
`timescale 1ns/1ps
module lvdc_sync
   import lvdc_pkg::*;
(
   // Clock and reset.
   input  wire logic ref_clk,
   input  wire logic rst,
   // Asynchronous level in, synchronised level out.
   input  wire logic async_in,
   output logic      sync_out
);

   typedef struct packed {
      logic stage1;
      logic stage2;
   } lvdc_sync_state_type;

   lvdc_sync_state_type q;
   lvdc_sync_state_type next_q;

   // The first stage feeds only the second stage.
   always_comb begin
      next_q.stage1 = async_in;
      next_q.stage2 = q.stage1;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign sync_out = q.stage2;

endmodule // lvdc_sync

// file: lvdc_sfr_access.sv
`timescale 1ns/1ps
module lvdc_sfr_access
   import lvdc_pkg::*;
(
   // Clock and reset.
   input  wire logic  ref_clk,
   input  wire logic  rst,
   // Special-function register port.
   input  wire logic [15:0] sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic        sfr_bit_op,
   input  wire logic [2:0]  sfr_bit_sel,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   // Register images and write strobes toward the core.
   lvdc_sfr_if.decoder      regs
);

   typedef struct packed {
      logic [7:0] rdata;
   } lvdc_acc_state_type;

   lvdc_acc_state_type q;
   lvdc_acc_state_type next_q;
   logic [7:0]         cur_value;

   // Address match, used for every register.
   function automatic logic addr_hit(input logic [15:0] a,
                                     input logic [15:0] target);
      return a == target;
   endfunction

   // A single-bit write changes one bit of the current image only.
   function automatic logic [7:0] merge(input logic [7:0] cur,
                                        input logic       bit_op,
                                        input logic [2:0] sel,
                                        input logic [7:0] wdata);
      logic [7:0] r;
      r = bit_op ? cur : wdata;
      if (bit_op) begin
         r[sel] = wdata[0];
      end
      return r;
   endfunction

   // Select the image of the addressed register; unmapped reads give zero.
   always_comb begin
      cur_value = 8'h00;
      if (addr_hit(sfr_addr, LVDC_ADDR_CONTROL)) begin
         cur_value = regs.control_q;
      end else if (addr_hit(sfr_addr, LVDC_ADDR_LEVEL)) begin
         cur_value = regs.level_q;
      end else if (addr_hit(sfr_addr, LVDC_ADDR_PORT_DIR)) begin
         cur_value = regs.port_dir_q;
      end
   end

   // Strobes and merged data for the core.
   assign regs.wr_control  = sfr_wr && addr_hit(sfr_addr, LVDC_ADDR_CONTROL);
   assign regs.wr_level    = sfr_wr && addr_hit(sfr_addr, LVDC_ADDR_LEVEL);
   assign regs.wr_port_dir = sfr_wr && addr_hit(sfr_addr, LVDC_ADDR_PORT_DIR);
   assign regs.wr_value    = merge(cur_value, sfr_bit_op, sfr_bit_sel,
                                   sfr_wdata);

   // Read data is captured one edge after the read strobe and held.
   always_comb begin
      next_q = q;
      if (sfr_rd) begin
         next_q.rdata = cur_value;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign sfr_rdata = q.rdata;

endmodule // lvdc_sfr_access

// file: lvdc_core_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the detector control block.
module lvdc_core_asserts
   import lvdc_pkg::*;
(
   // Clock and reset.
   input wire logic       ref_clk,
   input wire logic       rst,
   // Reset controller and interrupt side.
   input wire logic       other_reset,
   input wire logic       reset_source_clear,
   input wire logic       detector_reset,
   input wire logic       detector_reset_source_flag,
   input wire logic       detector_irq_mask_set,
   input wire logic       detector_irq,
   // Comparator and port side.
   input wire logic       comparator_below,
   input wire logic       comparator_enable,
   input wire logic       compare_external,
   input wire logic [3:0] comparator_level_code,
   input wire logic [4:0] port_pin_direction
);
   // All checks share one clock and one reset.
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // The low level needs two sync stages and the flag stage.
   a_irq_cause: assert property (
      $rose(detector_irq) |-> $past(comparator_below, 3))
      else $error("Interrupt rose without a low level.");
   a_reset_cause: assert property (
      $rose(detector_reset) |-> $past(comparator_below, 3))
      else $error("Internal reset rose without a low level.");
   a_reset_release: assert property (
      detector_reset && $fell(comparator_below) |-> ##4 !detector_reset)
      else $error("Internal reset not released in time.");
   a_disabled_quiet: assert property (
      !comparator_enable && !$past(comparator_enable)
         |-> !detector_irq && !detector_reset)
      else $error("Disabled detector still requests.");
   a_ext_code: assert property (
      compare_external |-> comparator_level_code == LVDC_LEVEL_UNUSED)
      else $error("Level code driven with the pin monitored.");
   a_src_set: assert property (
      detector_reset |=> detector_reset_source_flag)
      else $error("Reset source flag not set.");
   a_src_sticky: assert property (
      detector_reset_source_flag && !reset_source_clear
         |=> detector_reset_source_flag)
      else $error("Reset source flag lost.");
   a_mask_other: assert property (
      other_reset |=> detector_irq_mask_set)
      else $error("Mask not set by another reset.");
   a_other_clears: assert property (
      other_reset |=> !comparator_enable && !compare_external
         && port_pin_direction == 5'h1f)
      else $error("Another reset left control bits set.");

   // Main scenarios reached.
   c_irq: cover property ($rose(detector_irq));
   c_reset: cover property ($rose(detector_reset));
   c_other: cover property (other_reset ##1 detector_irq_mask_set);
endmodule // lvdc_core_asserts

bind lvdc_core lvdc_core_asserts lvdc_core_asserts_i (
   .ref_clk, .rst, .other_reset, .reset_source_clear, .detector_reset,
   .detector_reset_source_flag, .detector_irq_mask_set, .detector_irq,
   .comparator_below, .comparator_enable, .compare_external,
   .comparator_level_code, .port_pin_direction
);

// file: lvdc_comparator_model.sv
`timescale 1ns/1ps
// Behavioural analog comparator with levels given in millivolts.
module lvdc_comparator_model (
   // Control from the block.
   input  wire logic        comparator_enable,
   input  wire logic        compare_external,
   input  wire logic [3:0]  comparator_level_code,
   // Monitored levels set by the bench.
   input  wire logic [15:0] supply_mv,
   input  wire logic [15:0] ext_mv,
   // Comparator decision.
   output logic             comparator_below
);
   // Sixteen supply thresholds, code zero highest.
   int thr_mv [16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
                       3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};

   // An idle comparator reports nothing; the pin has a fixed threshold.
   always_comb begin
      if (!comparator_enable) begin
         comparator_below = 1'h0;
      end else if (compare_external) begin
         comparator_below = int'(ext_mv) < 1210;
      end else begin
         comparator_below = int'(supply_mv) < thr_mv[comparator_level_code];
      end
   end
endmodule // lvdc_comparator_model

// file: test_low_voltage_detect_control.sv
`timescale 1ns/1ps
module test_low_voltage_detect_control;
   import lvdc_pkg::*;

   // Stimulus driven by the bench.
   logic        ref_clk            = 1'h0;
   logic        rst                = 1'h1;
   logic [15:0] sfr_addr           = 16'h0000;
   logic        sfr_wr             = 1'h0;
   logic        sfr_rd             = 1'h0;
   logic        sfr_bit_op         = 1'h0;
   logic [2:0]  sfr_bit_sel        = 3'h0;
   logic [7:0]  sfr_wdata          = 8'h00;
   logic        other_reset        = 1'h0;
   logic        reset_source_clear = 1'h0;
   logic [15:0] supply_mv          = 16'h1388;
   logic [15:0] ext_mv             = 16'h07d0;
   // Observed outputs and counters.
   logic [7:0]  sfr_rdata;
   logic        detector_reset;
   logic        detector_reset_source_flag;
   logic        detector_irq_mask_set;
   logic        detector_irq;
   logic        comparator_below;
   logic        comparator_enable;
   logic        compare_external;
   logic [3:0]  comparator_level_code;
   logic [4:0]  port_pin_direction;
   int          error_cnt          = 0;
   int          total_checks       = 0;

   // Design and the comparator in front of it.
   lvdc_core lvdc_core_i (
      .ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_bit_op, .sfr_bit_sel,
      .sfr_wdata, .sfr_rdata, .other_reset, .reset_source_clear,
      .detector_reset, .detector_reset_source_flag, .detector_irq_mask_set,
      .detector_irq, .comparator_below, .comparator_enable,
      .compare_external, .comparator_level_code, .port_pin_direction
   );
   lvdc_comparator_model lvdc_comparator_model_i (
      .comparator_enable, .compare_external, .comparator_level_code,
      .supply_mv, .ext_mv, .comparator_below
   );

   // The clock toggles every half period of 10 ns.
   always #5 ref_clk = ~ref_clk;

   // Compares one value and counts the result.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Byte write; the request holds for the edge that takes it.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'h1;
      @(posedge ref_clk);
      sfr_wr    <= 1'h0;
   endtask

   // Single-bit write into the control register; the bit-op qualifier
   // rises and falls with the strobe, so back-to-back calls never clash.
   task automatic bwr(input logic [2:0] s, input logic v);
      @(posedge ref_clk);
      sfr_addr    <= LVDC_ADDR_CONTROL;
      sfr_wdata   <= {7'h00, v};
      sfr_bit_sel <= s;
      sfr_bit_op  <= 1'h1;
      sfr_wr      <= 1'h1;
      @(posedge ref_clk);
      sfr_wr      <= 1'h0;
      sfr_bit_op  <= 1'h0;
   endtask

   // Read and compare; data is valid one cycle after the request.
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd   <= 1'h1;
      @(posedge ref_clk);
      sfr_rd   <= 1'h0;
      #1;
      chk(sfr_rdata, exp);
   endtask

   // Sets the analog levels and lets them pass the synchroniser.
   task automatic volt(input int s, input int e);
      @(posedge ref_clk);
      supply_mv <= 16'(s);
      ext_mv    <= 16'(e);
      repeat (6) @(posedge ref_clk);
      #1;
   endtask

   // Pulses one reset controller input for a single cycle.
   task automatic pulse(input logic which);
      @(posedge ref_clk);
      if (which) other_reset <= 1'h1;
      else reset_source_clear <= 1'h1;
      @(posedge ref_clk);
      other_reset        <= 1'h0;
      reset_source_clear <= 1'h0;
      #1;
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Main sequence of register accesses and level changes.
   initial begin
      repeat (19) @(posedge ref_clk);
      #1;
      chk(detector_irq_mask_set, 8'h01);
      @(posedge ref_clk);
      rst <= 1'h0;
      rd(LVDC_ADDR_CONTROL, 8'h00);
      rd(LVDC_ADDR_LEVEL, 8'h00);
      rd(LVDC_ADDR_PORT_DIR, 8'hff);
      rd(16'hff00, 8'h00);
      chk(detector_irq_mask_set, 8'h00);
      chk(port_pin_direction, 8'h1f);
      wr(LVDC_ADDR_CONTROL, 8'hff);
      rd(LVDC_ADDR_CONTROL, 8'h86);
      chk(compare_external, 8'h01);
      wr(LVDC_ADDR_CONTROL, 8'h00);
      rd(LVDC_ADDR_CONTROL, 8'h00);
      wr(LVDC_ADDR_PORT_DIR, 8'h00);
      rd(LVDC_ADDR_PORT_DIR, 8'he0);
      chk(port_pin_direction, 8'h00);
      wr(LVDC_ADDR_PORT_DIR, 8'h01);
      // Every level code, just below and just above its threshold.
      for (int c = 0; c < 16; c++) begin
         wr(LVDC_ADDR_LEVEL, 8'(c));
         volt(lvdc_comparator_model_i.thr_mv[c] - 10, 2000);
         chk(comparator_level_code, 8'(c));
         wr(LVDC_ADDR_CONTROL, 8'h80);
         repeat (1000) @(posedge ref_clk);
         rd(LVDC_ADDR_CONTROL, 8'h81);
         chk(detector_irq, 8'h01);
         volt(lvdc_comparator_model_i.thr_mv[c] + 10, 2000);
         rd(LVDC_ADDR_CONTROL, 8'h80);
         chk(detector_irq, 8'h00);
         wr(LVDC_ADDR_CONTROL, 8'h00);
      end
      volt(1000, 2000);
      rd(LVDC_ADDR_CONTROL, 8'h00);
      chk(detector_irq, 8'h00);
      // Pin monitoring ignores the supply and the level code.
      wr(LVDC_ADDR_CONTROL, 8'h84);
      repeat (1000) @(posedge ref_clk);
      volt(5000, 1000);
      rd(LVDC_ADDR_CONTROL, 8'h85);
      chk(comparator_level_code, 8'h00);
      volt(1000, 1300);
      rd(LVDC_ADDR_CONTROL, 8'h84);
      wr(LVDC_ADDR_CONTROL, 8'h00);
      // Reset mode: arm above threshold, then drop the supply.
      wr(LVDC_ADDR_LEVEL, 8'h00);
      volt(5000, 2000);
      wr(LVDC_ADDR_CONTROL, 8'h80);
      repeat (1000) @(posedge ref_clk);
      rd(LVDC_ADDR_CONTROL, 8'h80);
      bwr(3'h1, 1'h1);
      volt(5000, 2000);
      chk(detector_reset, 8'h00);
      volt(4000, 2000);
      chk(detector_reset, 8'h01);
      chk(detector_reset_source_flag, 8'h01);
      wr(LVDC_ADDR_CONTROL, 8'h00);
      rd(LVDC_ADDR_CONTROL, 8'h83);
      rd(LVDC_ADDR_PORT_DIR, 8'hff);
      volt(5000, 2000);
      chk(detector_reset, 8'h00);
      rd(LVDC_ADDR_CONTROL, 8'h82);
      bwr(3'h1, 1'h0);
      bwr(3'h7, 1'h0);
      rd(LVDC_ADDR_CONTROL, 8'h00);
      // Another reset clears control but keeps the source flag.
      wr(LVDC_ADDR_CONTROL, 8'h84);
      pulse(1'h1);
      chk(detector_irq_mask_set, 8'h01);
      chk(detector_reset_source_flag, 8'h01);
      rd(LVDC_ADDR_CONTROL, 8'h00);
      pulse(1'h0);
      chk(detector_reset_source_flag, 8'h00);
      conclude();
   end
endmodule // test_low_voltage_detect_control
